// File: common/adc_seq_pkg.sv
// Shared constants and carrier types for the converter sequencer port
package adc_seq_pkg;
    localparam int unsigned CLK_PER_CONV = 14;      // Conversion clocks per channel
    localparam int unsigned INT_OSC_DIV = 4;        // Internal oscillator half period in clk cycles
    localparam int unsigned NUM_CH = 4;
    localparam int unsigned RES_W = 12;
    localparam int unsigned RES_MSB = 11;
    localparam logic [3:0] CH_MASK_RESET = 4'h0;
    localparam int unsigned EOC_PULSE_CYC = 1;       // Low width of end-of-conversion pulse

    // Host bus pins after synchronisation
    typedef struct packed {
        logic cs_n;
        logic rd_n;
        logic wr_n;
    } host_strobes_t;

    // Result word handed from converter to the output buffer
    typedef struct packed {
        logic [1:0] channel;
        logic [11:0] code;
    } result_word_t;
endpackage : adc_seq_pkg

// File: verilog/result_fifo.sv
// Small valid/ready FIFO holding converted result words
module result_fifo #(
    parameter int unsigned WIDTH = 14,
    parameter int unsigned DEPTH = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);
    typedef struct packed {
        logic [AW:0] wr_ptr;
        logic [AW:0] rd_ptr;
    } fifo_state_t;
    fifo_state_t state;
    fifo_state_t next_state;
    logic [WIDTH-1:0] mem [DEPTH];
    logic full;
    logic empty;

    // Full and empty from pointer wrap bits
    assign empty = state.wr_ptr == state.rd_ptr;
    assign full = (state.wr_ptr[AW-1:0] == state.rd_ptr[AW-1:0]) && (state.wr_ptr[AW] != state.rd_ptr[AW]);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[state.rd_ptr[AW-1:0]];

    // Pointer advance
    always_comb begin
        next_state = state;
        if (in_valid && !full) begin
            next_state.wr_ptr = state.wr_ptr + 1'b1;
        end
        if (out_ready && !empty) begin
            next_state.rd_ptr = state.rd_ptr + 1'b1;
        end
    end

    // State and storage
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= '0;
        end else begin
            state <= next_state;
        end
        if (in_valid && !full) begin
            mem[state.wr_ptr[AW-1:0]] <= in_data;
        end
    end
endmodule : result_fifo

// File: verilog/adc_sequencer.sv
// Conversion sequencer and parallel host port of a four-channel simultaneous converter
module adc_sequencer #(
    parameter bit BIPOLAR = 1'b1,
    parameter int unsigned FIFO_DEPTH = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Conversion control pins
    input wire logic clock_source_select,
    input wire logic conversion_clock_in,
    input wire logic sample_start_n,
    input wire logic sequence_source_select,
    input wire logic [3:0] hw_channel_pins,
    // Host strobes
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    // Data lines
    output logic [5:0] result_bits_high,
    output logic [1:0] result_bits_mid,
    output logic high_lines_oe,
    input wire logic [3:0] shared_low_data_in,
    output logic [3:0] shared_low_data_lines,
    output logic shared_low_oe,
    // Analog core interface
    input wire logic [11:0] sample_code,
    output logic [1:0] sample_channel,
    output logic hold,
    // Status
    output logic busy,
    output logic eoc_n
);
    localparam int unsigned CW = $clog2(adc_seq_pkg::CLK_PER_CONV + 1);

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_CONV = 2'b10
    } seq_state_t;

    typedef struct packed {
        logic [2:0] conv_clk_sync;
        logic [2:0] start_sync;
        logic [2:0] cs_sync;
        logic [2:0] rd_sync;
        logic [2:0] wr_sync;
        logic conv_lvl;
        logic start_lvl;
        logic cs_lvl;
        logic rd_lvl;
        logic wr_lvl;
        logic [3:0] ch_mask;
        logic [3:0] seq_set;
        seq_state_t fsm;
        logic [1:0] chan;
        logic [CW-1:0] clk_count;
        logic [7:0] osc_div;
        logic osc;
        logic busy;
        logic eoc_n;
        logic hold;
        logic [11:0] out_word;
        logic drive;
    } core_state_t;

    core_state_t state;
    core_state_t next_state;
    adc_seq_pkg::result_word_t push_word;
    adc_seq_pkg::result_word_t pop_word;
    logic push_valid;
    logic push_ready;
    logic pop_valid;
    logic pop_ready;
    logic conv_edge;
    logic conv_now;
    logic start_now;
    logic cs_now;
    logic rd_now;
    logic wr_now;
    logic start_rise;
    logic wr_rise;
    logic rd_fall;
    logic reading;
    logic [3:0] remaining;
    logic [1:0] next_chan;

    // Stable views of asynchronous pins from the last two stages
    function automatic logic settled(input logic [2:0] s, input logic prev);
        settled = (s[1] == s[2]) ? s[1] : prev;
    endfunction : settled

    // Settled levels: a pin change counts once the second and third stages agree
    assign conv_now = settled(state.conv_clk_sync, state.conv_lvl);
    assign start_now = settled(state.start_sync, state.start_lvl);
    assign cs_now = settled(state.cs_sync, state.cs_lvl);
    assign rd_now = settled(state.rd_sync, state.rd_lvl);
    assign wr_now = settled(state.wr_sync, state.wr_lvl);

    // Edges of the settled levels
    assign start_rise = start_now && !state.start_lvl;
    assign reading = !state.cs_lvl && !state.rd_lvl;
    assign wr_rise = wr_now && !state.wr_lvl && !state.cs_lvl && state.rd_lvl;
    assign rd_fall = !rd_now && state.rd_lvl && !cs_now;

    // Conversion clock edge: internal divider or external input
    always_comb begin
        if (clock_source_select) begin
            conv_edge = conv_now && !state.conv_lvl;
        end else begin
            conv_edge = (state.osc_div == 8'(adc_seq_pkg::INT_OSC_DIV - 1)) && !state.osc;
        end
    end

    // Remaining selected channels above the current one, ascending
    always_comb begin
        remaining = '0;
        next_chan = state.chan;
        for (int i = adc_seq_pkg::NUM_CH - 1; i >= 0; i--) begin
            if (state.seq_set[i] && (i > int'(state.chan))) begin
                remaining[i] = 1'b1;
                next_chan = 2'(i);
            end
        end
    end

    // Result push after each conversion, popped on read
    assign push_word.channel = state.chan;
    assign push_word.code = sample_code;
    assign push_valid = (state.fsm == ST_CONV) && conv_edge
        && (state.clk_count == CW'(adc_seq_pkg::CLK_PER_CONV - 1));
    assign pop_ready = rd_fall;

    // Next state of the whole block
    always_comb begin
        next_state = state;
        next_state.conv_clk_sync = {state.conv_clk_sync[1:0], conversion_clock_in};
        next_state.start_sync = {state.start_sync[1:0], sample_start_n};
        next_state.cs_sync = {state.cs_sync[1:0], cs_n};
        next_state.rd_sync = {state.rd_sync[1:0], rd_n};
        next_state.wr_sync = {state.wr_sync[1:0], wr_n};
        next_state.conv_lvl = conv_now;
        next_state.start_lvl = start_now;
        next_state.cs_lvl = cs_now;
        next_state.rd_lvl = rd_now;
        next_state.wr_lvl = wr_now;
        next_state.osc_div = (state.osc_div == 8'(adc_seq_pkg::INT_OSC_DIV - 1)) ? 8'h00 : state.osc_div + 8'h01;
        if (state.osc_div == 8'(adc_seq_pkg::INT_OSC_DIV - 1)) begin
            next_state.osc = !state.osc;
        end
        next_state.eoc_n = 1'b1;
        if (wr_rise) begin
            next_state.ch_mask = shared_low_data_in;
        end
        unique case (state.fsm)
            ST_IDLE: begin
                if (start_rise) begin
                    next_state.seq_set = sequence_source_select ? state.ch_mask : hw_channel_pins;
                    next_state.hold = 1'b1;
                    next_state.clk_count = '0;
                    if ((sequence_source_select ? state.ch_mask : hw_channel_pins) != 4'h0) begin
                        next_state.busy = 1'b1;
                        next_state.fsm = ST_CONV;
                        next_state.chan = 2'h0;
                        for (int i = adc_seq_pkg::NUM_CH - 1; i >= 0; i--) begin
                            if ((sequence_source_select ? state.ch_mask[i] : hw_channel_pins[i])) begin
                                next_state.chan = 2'(i);
                            end
                        end
                    end else begin
                        next_state.hold = 1'b0;
                    end
                end
            end
            ST_CONV: begin
                if (conv_edge) begin
                    if (state.clk_count == CW'(adc_seq_pkg::CLK_PER_CONV - 1)) begin
                        if (push_ready) begin
                            next_state.clk_count = '0;
                            next_state.eoc_n = 1'b0;
                            if (remaining == 4'h0) begin
                                next_state.fsm = ST_IDLE;
                                next_state.busy = 1'b0;
                                next_state.hold = 1'b0;
                            end else begin
                                next_state.chan = next_chan;
                            end
                        end
                    end else begin
                        next_state.clk_count = state.clk_count + CW'(1);
                    end
                end
            end
        endcase
        // Read latches the oldest result; empty buffer shows zero
        if (rd_fall) begin
            next_state.out_word = pop_valid ? pop_word.code : 12'h000;
        end
        next_state.drive = reading;
    end

    // Register the state
    always_ff @(posedge clk) begin
        if (rst) begin
            state <= '0;
            state.start_sync <= 3'h7;
            state.cs_sync <= 3'h7;
            state.rd_sync <= 3'h7;
            state.wr_sync <= 3'h7;
            state.start_lvl <= 1'b1; // Idle high levels, so no false edge after reset
            state.cs_lvl <= 1'b1;
            state.rd_lvl <= 1'b1;
            state.wr_lvl <= 1'b1;
            state.ch_mask <= adc_seq_pkg::CH_MASK_RESET;
            state.fsm <= ST_IDLE;
            state.eoc_n <= 1'b1;
        end else begin
            state <= next_state;
        end
    end

    result_fifo #(
        .WIDTH($bits(adc_seq_pkg::result_word_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .rst(rst),
        .in_valid(push_valid),
        .in_ready(push_ready),
        .in_data(push_word),
        .out_valid(pop_valid),
        .out_ready(pop_ready),
        .out_data(pop_word)
    );

    // Pin outputs, all from flip-flops
    assign result_bits_high = state.out_word[adc_seq_pkg::RES_MSB -: 6];
    assign result_bits_mid = state.out_word[5:4];
    assign shared_low_data_lines = state.out_word[3:0];
    assign high_lines_oe = state.drive;
    assign shared_low_oe = state.drive;
    assign sample_channel = state.chan;
    assign hold = state.hold;
    assign busy = state.busy;
    assign eoc_n = state.eoc_n;
endmodule : adc_sequencer

// File: dv/adc_sequencer_asserts.sv
// Port-level assertions for the conversion sequencer
module adc_seq_checker (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Watched pins
    input wire logic clock_source_select,
    input wire logic sample_start_n,
    input wire logic cs_n,
    input wire logic high_lines_oe,
    input wire logic shared_low_oe,
    input wire logic hold,
    input wire logic busy,
    input wire logic eoc_n
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    int unsigned gap;
    // Cycles since sequence start or the last end pulse
    always_ff @(posedge clk) begin
        if (rst || $rose(busy) || $fell(eoc_n)) begin
            gap <= 0;
        end else begin
            gap <= gap + 1;
        end
    end
    a_oe_pair: assert property (high_lines_oe == shared_low_oe) else $error("enables differ");
    a_oe_idle: assert property (cs_n [*6] |-> !high_lines_oe) else $error("bus driven unselected");
    a_eoc_single: assert property ($fell(eoc_n) |=> eoc_n) else $error("end pulse too wide");
    a_eoc_in_seq: assert property (!eoc_n |-> $past(busy)) else $error("end pulse outside sequence");
    a_busy_end: assert property ($fell(busy) |-> !eoc_n) else $error("busy fell without end pulse");
    a_hold_busy: assert property (hold == busy) else $error("hold and busy disagree");
    a_busy_start: assert property ($rose(busy) |-> $past(sample_start_n, 3) && $past(sample_start_n, 4)
        && !$past(sample_start_n, 5)) else $error("busy rose without start edge");
    a_eoc_gap: assert property ($fell(eoc_n) && !clock_source_select |-> gap >= 100)
        else $error("conversion shorter than fourteen clocks");
endmodule : adc_seq_checker

bind adc_sequencer adc_seq_checker chk_u (.clk(clk), .rst(rst), .clock_source_select(clock_source_select),
    .sample_start_n(sample_start_n), .cs_n(cs_n), .high_lines_oe(high_lines_oe), .shared_low_oe(shared_low_oe),
    .hold(hold), .busy(busy), .eoc_n(eoc_n));

// File: dv/host_bus_model.sv
// Host processor model on the parallel data bus
module host_bus_model (
    // Clock
    input wire logic clk,
    // Bus from the device
    input wire logic [5:0] high,
    input wire logic [1:0] mid,
    input wire logic [3:0] low,
    input wire logic oe,
    // Strobes and low lines to the device
    output logic cs_n,
    output logic rd_n,
    output logic wr_n,
    output logic [3:0] din
);
    timeunit 1ns;
    timeprecision 1ps;
    logic drv = 1'b0;
    logic [3:0] wd = 4'h0;
    initial {cs_n, rd_n, wr_n} = 3'h7;
    // Wire level: device, host, or the complement of the last written mask when nobody drives
    assign din = oe ? low : (drv ? wd : ~wd);
    // Write the channel mask, data held past the strobe rise
    task automatic wr(input logic [3:0] m);
        @(posedge clk) begin cs_n <= 1'b0; wd <= m; drv <= 1'b1; end
        repeat (5) @(posedge clk);
        wr_n <= 1'b0;
        repeat (5) @(posedge clk);
        wr_n <= 1'b1;
        repeat (5) @(posedge clk);
        cs_n <= 1'b1;
        drv <= 1'b0;
    endtask : wr
    // Read one word; unknown unless the device drives
    task automatic rd(output logic [11:0] w);
        @(posedge clk) begin cs_n <= 1'b0; rd_n <= 1'b0; end
        repeat (8) @(posedge clk);
        w = (oe === 1'b1) ? {high, mid, low} : 12'hxxx;
        rd_n <= 1'b1;
        cs_n <= 1'b1;
        repeat (6) @(posedge clk);
    endtask : rd
endmodule : host_bus_model

// File: dv/simultaneous_adc_sequencer_port_tb.sv
// Self-checking bench for the conversion sequencer
module simultaneous_adc_sequencer_port_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst = 1'b1, src = 1'b0, ext = 1'b0, start_n = 1'b1, seqsel = 1'b0;
    logic cs_n, rd_n, wr_n, hoe, loe, hold, busy, eoc_n;
    logic [3:0] hw = 4'h0, din, low;
    logic [5:0] high;
    logic [1:0] mid, ch;
    logic [11:0] tbl [4], w;
    logic [31:0] seed = 32'ha4e8868f;
    int fails = 0, checked = 0, n, t;
    logic [11:0] q [$];
    logic [3:0] m;
    initial forever #2.5 clk = ~clk;
    initial forever #10 ext = ~ext;
    // Core returns the code of the channel it is asked for
    wire [11:0] tbl_code;
    assign tbl_code = tbl[ch];
    adc_sequencer dut_u (.clk(clk), .rst(rst), .clock_source_select(src), .conversion_clock_in(ext),
        .sample_start_n(start_n), .sequence_source_select(seqsel), .hw_channel_pins(hw), .cs_n(cs_n),
        .rd_n(rd_n), .wr_n(wr_n), .result_bits_high(high), .result_bits_mid(mid), .high_lines_oe(hoe),
        .shared_low_data_in(din), .shared_low_data_lines(low), .shared_low_oe(loe), .sample_code(tbl_code),
        .sample_channel(ch), .hold(hold), .busy(busy), .eoc_n(eoc_n));
    host_bus_model host_u (.clk(clk), .high(high), .mid(mid), .low(low), .oe(hoe), .cs_n(cs_n), .rd_n(rd_n),
        .wr_n(wr_n), .din(din));
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic conclude();
        $display("checks %0d mismatches %0d", checked, fails);
        if (fails == 0 && checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : conclude
    // Main sequence: mask source, clock source and channel sets in turn
    initial begin
        foreach (tbl[i]) tbl[i] = 12'h000;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        check({busy, eoc_n, hoe, hold}, 16'h4);
        repeat (4) @(posedge clk);
        for (int i = 0; i < 6; i++) begin
            m = (i == 0) ? 4'hf : (i == 1) ? 4'h8 : 4'(rnd());
            if (m == 4'h0) m = 4'h5;
            @(posedge clk) begin src <= i[0]; seqsel <= i[1]; hw <= i[1] ? ~m : m; end
            foreach (tbl[k]) tbl[k] <= 12'(rnd());
            host_u.wr(i[1] ? m : ~m);
            @(posedge clk) start_n <= 1'b0;
            repeat (6) @(posedge clk);
            start_n <= 1'b1;
            n = 0;
            for (t = 0; t < 3000 && !(busy === 1'b1); t++) @(posedge clk);
            if (t >= 3000) begin
                fails++;
                conclude();
            end
            @(posedge clk) hw <= 4'(rnd());
            for (t = 0; t < 3000 && busy !== 1'b0; t++) begin
                @(posedge clk);
                if (eoc_n === 1'b0) n++;
            end
            if (t >= 3000) begin fails++; conclude(); end
            q = {};
            for (int c = 0; c < 4; c++) if (m[c]) q.push_back(tbl[c]);
            check(16'(n), 16'(q.size()));
            while (q.size() > 0) begin
                host_u.rd(w);
                check(w, q.pop_front());
            end
            // A read with no result left shows zero
            host_u.rd(w);
            check(w, 16'h0000);
            $display("test %0d done", i);
        end
        conclude();
    end
endmodule : simultaneous_adc_sequencer_port_tb
